// file: include/map_defines.svh
// constants for the multiplexed address command port
// assumes inclusion by bare name from the design and test files
`ifndef MAP_DEFINES_SVH
`define MAP_DEFINES_SVH
`define MAP_ADDR_W        21
`define MAP_MUX_EN_BIT    9
`define MAP_CFG_W         18
`define MAP_BL_LSB        3
`define MAP_CFG1_ZQ_BIT   7
`define MAP_RTT_LSB       2
`define MAP_CFG_RST       18'h00000
`define MAP_CMD_W         3
`define MAP_LAT_W         4
`define MAP_TRC_NS        8
`define MAP_CLK_MHZ       250
`define MAP_TRC_CYC       ((`MAP_TRC_NS * `MAP_CLK_MHZ + 999) / 1000)
`define MAP_RD_LAT        4'h5
`define MAP_WR_LAT        4'h6
`endif

// file: include/map_pkg.sv
// types for the multiplexed address command port
// assumes map_defines.svh is on the include path
package map_pkg;
  typedef enum logic [2:0]
  {
    MAP_CMD_NOP   = 3'b000,
    MAP_CMD_MRS   = 3'b001,
    MAP_CMD_RD    = 3'b010,
    MAP_CMD_WR    = 3'b011,
    MAP_CMD_BREF  = 3'b100,
    MAP_CMD_MBREF = 3'b101
  } map_cmd_t;
  typedef enum logic [1:0]
  {
    MAP_ST_IDLE = 2'b00,
    MAP_ST_HALF = 2'b01
  } map_state_t;
endpackage : map_pkg

// file: hdl/map_latency.sv
// data latency counter started on the second-half edge in mux mode, the only edge in direct mode
// assumes start pulses from the same clock domain
`include "map_defines.svh"
`timescale 1ns/1ps
module map_latency
(
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    start_i,
  input  wire logic [`MAP_LAT_W-1:0]   lat_i,
  output logic                         done_o
);
  logic [`MAP_LAT_W-1:0] cnt_q;
  logic                  run_q;
  // a new start restarts the count; back to back bursts overlap in the host
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end
    else if (start_i)
    begin
      cnt_q <= lat_i;
      run_q <= 1'b1;
    end
    else if (run_q && cnt_q != '0)
    begin
      cnt_q <= cnt_q - 4'h1;
    end
    else
    begin
      run_q <= 1'b0;
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      done_o <= 1'b0;
    else
      done_o <= run_q && !start_i && cnt_q == 4'h1;
  end
endmodule : map_latency

// file: hdl/map_port.sv
// command and address decoder for multiplexed addressing
// assumes synchronous command pins; host keeps its own ordering duties
`include "map_defines.svh"
`timescale 1ns/1ps
module map_port
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   dev_rst_n_i,
  input  wire logic                   wide_i,
  input  wire logic [`MAP_CMD_W-1:0]  cmd_i,
  input  wire logic [3:0]             bank_i,
  input  wire logic [`MAP_CFG_W:0]    addr_i,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [3:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic [31:0]                 wb_dat_o,
  output logic                        wb_ack_o,
  output logic                        mux_mode_o,
  output logic                        exec_o,
  output logic [`MAP_CMD_W-1:0]       exec_cmd_o,
  output logic [3:0]                  exec_bank_o,
  output logic [`MAP_ADDR_W-1:0]      exec_addr_o,
  output logic                        data_go_o,
  output logic                        row_busy_o,
  output logic [1:0]                  rtt_sel_o,
  output logic                        rtt_en_o
);
  // ********************************************************
  // pin synchronisers
  // ********************************************************
  logic [`MAP_CMD_W-1:0] cmd_s1, cmd_s2;
  logic [3:0]            bank_s1, bank_s2;
  logic [`MAP_CFG_W:0]   addr_s1, addr_s2;
  logic [1:0]            rstn_s;
  logic [1:0]            wide_s;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cmd_s1  <= '0;
      cmd_s2  <= '0;
      bank_s1 <= '0;
      bank_s2 <= '0;
      addr_s1 <= '0;
      addr_s2 <= '0;
      rstn_s  <= 2'b00;
      wide_s  <= 2'b00;
    end
    else
    begin
      cmd_s1  <= cmd_i;
      cmd_s2  <= cmd_s1;
      bank_s1 <= bank_i;
      bank_s2 <= bank_s1;
      addr_s1 <= addr_i;
      addr_s2 <= addr_s1;
      rstn_s  <= {rstn_s[0], dev_rst_n_i};
      wide_s  <= {wide_s[0], wide_i};
    end
  end
  logic dev_rst;
  assign dev_rst = rst_i || !rstn_s[1];

  // ********************************************************
  // address merge function
  // ********************************************************
  // second-half lines 3,4,8,9,13,14,17,18 carry bits 1,2,6,7,11,12,16,15
  function automatic logic [`MAP_ADDR_W-1:0] map_merge
  (
    input logic [`MAP_CFG_W:0] ax,
    input logic [`MAP_CFG_W:0] ay,
    input logic                wide,
    input logic [1:0]          bl
  );
    logic [`MAP_ADDR_W-1:0] a;
    a     = '0;
    a[0]  = ax[0];
    a[3]  = ax[3];
    a[4]  = ax[4];
    a[5]  = ax[5];
    a[8]  = ax[8];
    a[9]  = ax[9];
    a[10] = ax[10];
    a[13] = ax[13];
    a[14] = ax[14];
    a[17] = ax[17];
    a[18] = ax[18];
    a[1]  = ay[3];
    a[2]  = ay[4];
    a[6]  = ay[8];
    a[7]  = ay[9];
    a[11] = ay[13];
    a[12] = ay[14];
    a[16] = ay[17];
    a[15] = ay[18];
    // bl: 0 = burst 2, 1 = burst 4, 2 = burst 8
    if (bl == 2'd0 || (!wide && bl == 2'd1))
      a[19] = ay[10];
    if (!wide && bl == 2'd0)
      a[20] = ay[5];
    return a;
  endfunction : map_merge

  // ********************************************************
  // mode state and command capture
  // ********************************************************
  map_pkg::map_state_t    st_q;
  logic                   mux_q;
  logic [`MAP_CMD_W-1:0]  cmd_q;
  logic [3:0]             bank_q;
  logic [`MAP_CFG_W:0]    ax_q;
  logic [`MAP_CFG_W-1:0]  cfg0_q, cfg1_q, cfg2_q;
  logic                   cfg2_done_q;
  logic [`MAP_ADDR_W-1:0] full_addr;
  logic [1:0]             bl_cur;
  logic                   cmd_valid;
  map_pkg::map_cmd_t      cmd_e;
  logic                   take_next;
  assign cmd_e     = map_pkg::map_cmd_t'(cmd_s2);
  assign cmd_valid = cmd_e != map_pkg::MAP_CMD_NOP;
  // a bank refresh has no second half, so its second edge may already open the next command
  assign take_next = mux_q && cmd_valid && st_q == map_pkg::MAP_ST_HALF
                     && cmd_q == map_pkg::MAP_CMD_BREF;
  assign bl_cur    = cfg0_q[`MAP_BL_LSB+1:`MAP_BL_LSB];
  assign full_addr = map_merge(ax_q, addr_s2, wide_s[1], bl_cur);

  always_ff @(posedge clk_i)
  begin
    if (dev_rst)
    begin
      st_q   <= map_pkg::MAP_ST_IDLE;
      cmd_q  <= '0;
      bank_q <= '0;
      ax_q   <= '0;
    end
    else
    begin
      case (st_q)
        map_pkg::MAP_ST_IDLE:
        begin
          if (mux_q && cmd_valid)
          begin
            st_q   <= map_pkg::MAP_ST_HALF;
            cmd_q  <= cmd_s2;
            bank_q <= bank_s2;
            ax_q   <= addr_s2;
          end
        end
        map_pkg::MAP_ST_HALF:
        begin
          if (take_next)
          begin
            cmd_q  <= cmd_s2;
            bank_q <= bank_s2;
            ax_q   <= addr_s2;
          end
          else
            st_q <= map_pkg::MAP_ST_IDLE;
        end
        default:
          st_q <= map_pkg::MAP_ST_IDLE;
      endcase
    end
  end

  // one-cycle execute strobe; direct mode executes at once
  logic                   ex_now;
  logic [`MAP_CMD_W-1:0]  ex_cmd;
  logic [3:0]             ex_bank;
  logic [`MAP_ADDR_W-1:0] ex_addr;
  always_comb
  begin
    ex_now  = 1'b0;
    ex_cmd  = cmd_s2;
    ex_bank = bank_s2;
    ex_addr = {2'b00, addr_s2[`MAP_CFG_W:0]};
    if (!mux_q)
      ex_now = cmd_valid;
    else if (st_q == map_pkg::MAP_ST_HALF)
    begin
      ex_now  = 1'b1;
      ex_cmd  = cmd_q;
      ex_bank = bank_q;
      ex_addr = full_addr;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (dev_rst)
    begin
      exec_o      <= 1'b0;
      exec_cmd_o  <= '0;
      exec_bank_o <= '0;
      exec_addr_o <= '0;
    end
    else
    begin
      exec_o     <= ex_now;
      exec_cmd_o <= ex_now ? ex_cmd : '0;
      // bank-controlled refresh drops the address, multibank drops the bank
      exec_bank_o <= (ex_cmd == map_pkg::MAP_CMD_MBREF) ? 4'h0 : ex_bank;
      exec_addr_o <= (ex_cmd == map_pkg::MAP_CMD_BREF) ? '0 : ex_addr;
    end
  end

  // ********************************************************
  // mode configuration
  // ********************************************************
  logic is_mrs;
  logic [1:0] mrs_sel;
  assign is_mrs  = ex_now && ex_cmd == map_pkg::MAP_CMD_MRS;
  assign mrs_sel = ex_bank[1:0];
  always_ff @(posedge clk_i)
  begin
    if (dev_rst)
    begin
      mux_q       <= 1'b0;
      cfg0_q      <= `MAP_CFG_RST;
      cfg1_q      <= `MAP_CFG_RST;
      cfg2_q      <= `MAP_CFG_RST;
      cfg2_done_q <= 1'b0;
    end
    else if (is_mrs)
    begin
      case (mrs_sel)
        2'd0:
        begin
          cfg0_q <= ex_addr[`MAP_CFG_W-1:0];
          if (ex_addr[`MAP_MUX_EN_BIT])
            mux_q <= 1'b1;
        end
        2'd1:
          cfg1_q <= ex_addr[`MAP_CFG_W-1:0];
        2'd2:
        begin
          cfg2_q      <= ex_addr[`MAP_CFG_W-1:0];
          cfg2_done_q <= 1'b1;
        end
        default:
          cfg2_done_q <= cfg2_done_q;
      endcase
    end
  end
  assign mux_mode_o = mux_q;
  always_ff @(posedge clk_i)
  begin
    if (dev_rst)
    begin
      rtt_en_o  <= 1'b0;
      rtt_sel_o <= 2'b00;
    end
    else
    begin
      rtt_en_o  <= cfg2_done_q && cfg1_q[`MAP_RTT_LSB+1:`MAP_RTT_LSB] != 2'b00;
      rtt_sel_o <= cfg2_done_q ? cfg1_q[`MAP_RTT_LSB+1:`MAP_RTT_LSB] : 2'b00;
    end
  end

  // ********************************************************
  // latency and row cycle
  // ********************************************************
  logic rw_start;
  logic [`MAP_LAT_W-1:0] lat_sel;
  assign rw_start = ex_now && (ex_cmd == map_pkg::MAP_CMD_RD || ex_cmd == map_pkg::MAP_CMD_WR);
  assign lat_sel  = (ex_cmd == map_pkg::MAP_CMD_WR) ? `MAP_WR_LAT : `MAP_RD_LAT;
  map_latency u_lat
  (
    .clk_i   (clk_i),
    .rst_i   (dev_rst),
    .start_i (rw_start),
    .lat_i   (lat_sel),
    .done_o  (data_go_o)
  );
  logic [3:0] trc_q;
  logic       row_start;
  // first-half edge in mux mode, the only edge in direct mode
  assign row_start = mux_q ? ((st_q == map_pkg::MAP_ST_IDLE && cmd_valid) || take_next) : cmd_valid;
  always_ff @(posedge clk_i)
  begin
    if (dev_rst)
      trc_q <= 4'h0;
    else if (row_start)
      trc_q <= 4'(`MAP_TRC_CYC);
    else if (trc_q != 4'h0)
      trc_q <= trc_q - 4'h1;
  end
  assign row_busy_o = trc_q != 4'h0;

  // ********************************************************
  // wishbone status slave
  // ********************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      case (wb_adr_i)
        4'h0: wb_dat_o <= {29'h0, cfg2_done_q, rtt_en_o, mux_q};
        4'h4: wb_dat_o <= {14'h0, cfg0_q};
        4'h8: wb_dat_o <= {14'h0, cfg1_q};
        4'hc: wb_dat_o <= {14'h0, cfg2_q};
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end
endmodule : map_port

// file: test/map_host.sv
// partner model: memory controller driving command, bank and address pins
// assumes one shared clock; the caller keeps the power-up order
`timescale 1ns/1ps
module map_host
#(
  parameter int MRSC = 12  // mode-set recovery in cycles, plain default
)
(
  input  wire logic        clk_i,
  output logic [2:0]       cmd_o,
  output logic [3:0]       bank_o,
  output logic [18:0]      addr_o
);
  // ************************************************
  // command issue
  // ************************************************
  initial
  begin
    cmd_o  = map_pkg::MAP_CMD_NOP;
    bank_o = 4'h0;
    addr_o = 19'h00000;
  end
  task automatic put(input map_pkg::map_cmd_t c, input logic [3:0] b, input logic [18:0] x);
    @(posedge clk_i);
    cmd_o  <= c;
    bank_o <= (c == map_pkg::MAP_CMD_MRS) ? {2'b00, b[1:0]} : b;
    addr_o <= x;
  endtask : put
  // single-cycle command, used only outside multiplexed mode
  task automatic cmd1(input map_pkg::map_cmd_t c, input logic [3:0] b, input logic [18:0] x);
    put(c, b, x);
    @(posedge clk_i);
    cmd_o  <= map_pkg::MAP_CMD_NOP;
    addr_o <= ~x;  // released pins must not keep the last value
    if (c == map_pkg::MAP_CMD_MRS && x[9])
      repeat (MRSC) @(posedge clk_i);
  endtask : cmd1
  // two-cycle command; bank refresh may be followed at once
  task automatic cmd2(input map_pkg::map_cmd_t c, input logic [3:0] b, input logic [18:0] x,
                      input logic [18:0] y);
    put(c, b, x);
    @(posedge clk_i);
    cmd_o  <= map_pkg::MAP_CMD_NOP;
    addr_o <= y;
    @(posedge clk_i);
    addr_o <= ~y;
    if (c == map_pkg::MAP_CMD_MBREF)
      repeat (2) @(posedge clk_i);
  endtask : cmd2
endmodule : map_host

// file: test/map_port_props.sv
// checker for the command port, bound into map_port
// assumes one command in flight at a time
`include "map_defines.svh"
`timescale 1ns/1ps
module map_port_props
(
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire logic                   dev_rst_n_i,
  input wire logic                   wide_i,
  input wire logic [`MAP_CMD_W-1:0]  cmd_i,
  input wire logic [3:0]             bank_i,
  input wire logic [`MAP_CFG_W:0]    addr_i,
  input wire logic                   mux_mode_o,
  input wire logic                   exec_o,
  input wire logic [`MAP_CMD_W-1:0]  exec_cmd_o,
  input wire logic [3:0]             exec_bank_o,
  input wire logic [`MAP_ADDR_W-1:0] exec_addr_o,
  input wire logic                   data_go_o,
  input wire logic                   row_busy_o
);
  // ************************************************
  // halves of the last command
  // ************************************************
  logic [`MAP_CFG_W:0] ax_q;
  logic [`MAP_CFG_W:0] ay_q;
  logic                sec_q;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  always_ff @(posedge clk_i)
  begin
    sec_q <= (cmd_i != map_pkg::MAP_CMD_NOP) && !rst_i;
    if (cmd_i != map_pkg::MAP_CMD_NOP)
    begin
      ax_q <= addr_i;
    end
    if (sec_q)
      ay_q <= addr_i;
  end
  property p_enter;
    !mux_mode_o && cmd_i == map_pkg::MAP_CMD_MRS && bank_i[1:0] == 2'b00 && addr_i[9] |-> ##[2:6] mux_mode_o;
  endproperty
  a_enter: assert property (p_enter) else $error("mode not entered");
  property p_stay;
    mux_mode_o && dev_rst_n_i && $past(dev_rst_n_i) && $past(dev_rst_n_i, 2) && $past(dev_rst_n_i, 4)
      |=> mux_mode_o;
  endproperty
  a_stay: assert property (p_stay) else $error("mode lost");
  property p_map;
    exec_o && mux_mode_o && exec_cmd_o == map_pkg::MAP_CMD_RD |-> exec_addr_o[10:8] == ax_q[10:8]
      && exec_addr_o[2:1] == ay_q[4:3] && exec_addr_o[16:15] == {ay_q[17], ay_q[18]};
  endproperty
  a_map: assert property (p_map) else $error("half mapping wrong");
  property p_hi;
    exec_o && mux_mode_o && !wide_i && exec_cmd_o == map_pkg::MAP_CMD_WR
      |-> exec_addr_o[20:19] == {ay_q[5], ay_q[10]};
  endproperty
  a_hi: assert property (p_hi) else $error("upper bits wrong");
  property p_lat;
    exec_o && exec_cmd_o == map_pkg::MAP_CMD_RD |-> ##[4:7] data_go_o;
  endproperty
  a_lat: assert property (p_lat) else $error("no data start");
  property p_row;
    cmd_i == map_pkg::MAP_CMD_RD |-> ##[1:6] row_busy_o;
  endproperty
  a_row: assert property (p_row) else $error("row cycle missing");
  property p_ref;
    mux_mode_o && cmd_i == map_pkg::MAP_CMD_BREF |-> ##[3:6] exec_o && exec_cmd_o == map_pkg::MAP_CMD_BREF;
  endproperty
  a_ref: assert property (p_ref) else $error("refresh not run");
  property p_bank;
    exec_o && exec_cmd_o == map_pkg::MAP_CMD_BREF
      |-> exec_bank_o == (mux_mode_o ? $past(bank_i, 4) : $past(bank_i, 3));
  endproperty
  a_bank: assert property (p_bank) else $error("refresh bank wrong");
  property p_mb;
    exec_o && mux_mode_o && exec_cmd_o == map_pkg::MAP_CMD_MBREF
      |-> exec_addr_o[13] == ax_q[13] && exec_addr_o[11] == ay_q[13];
  endproperty
  a_mb: assert property (p_mb) else $error("multibank address wrong");
  property p_rst;
    disable iff (1'b0) rst_i |=> !mux_mode_o && !exec_o && !data_go_o;
  endproperty
  a_rst: assert property (p_rst) else $error("reset not clean");
endmodule : map_port_props
bind map_port map_port_props u_props (.clk_i(clk_i), .rst_i(rst_i), .dev_rst_n_i(dev_rst_n_i), .wide_i(wide_i),
  .cmd_i(cmd_i), .bank_i(bank_i), .addr_i(addr_i), .mux_mode_o(mux_mode_o), .exec_o(exec_o),
  .exec_cmd_o(exec_cmd_o), .exec_bank_o(exec_bank_o), .exec_addr_o(exec_addr_o), .data_go_o(data_go_o),
  .row_busy_o(row_busy_o));

// file: test/map_port_tb.sv
// self-checking bench for map_port with a controller model
// assumes burst of two throughout; the device reset test switches to the x36 part for the last test
`include "map_defines.svh"
`timescale 1ns/1ps
module map_port_tb;
  // ************************************************
  // bench
  // ************************************************
  typedef struct {map_pkg::map_cmd_t c; logic [3:0] b; logic [18:0] x; logic [18:0] y; logic [3:0] l;} map_row_t;
  logic clk, rst, drst_n, cyc, stb, we, mux, ex, go, busy, ren, ack, wide;
  logic [2:0] cmd, ex_cmd;
  logic [3:0] bank, adr, ex_bank;
  logic [18:0] addr;
  logic [20:0] ex_addr;
  logic [31:0] rd, d;
  logic [1:0] rsel;
  int fail_count, tests_run, n;
  map_row_t rows [4] = '{'{map_pkg::MAP_CMD_RD, 4'h3, 19'h5a5a5, 19'h2a5a5, `MAP_RD_LAT},
    '{map_pkg::MAP_CMD_WR, 4'hc, 19'h7ffff, 19'h00421, `MAP_WR_LAT},
    '{map_pkg::MAP_CMD_BREF, 4'h9, 19'h00000, 19'h00000, 4'h0},
    '{map_pkg::MAP_CMD_MBREF, 4'h6, 19'h12345, 19'h6789a, 4'h0}};
  map_host host (.clk_i(clk), .cmd_o(cmd), .bank_o(bank), .addr_o(addr));
  map_port DUT (.clk_i(clk), .rst_i(rst), .dev_rst_n_i(drst_n), .wide_i(wide), .cmd_i(cmd), .bank_i(bank),
    .addr_i(addr), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(32'hffffffff), .wb_dat_o(rd), .wb_ack_o(ack), .mux_mode_o(mux), .exec_o(ex),
    .exec_cmd_o(ex_cmd), .exec_bank_o(ex_bank), .exec_addr_o(ex_addr), .data_go_o(go), .row_busy_o(busy),
    .rtt_sel_o(rsel), .rtt_en_o(ren));
  function automatic logic [20:0] mrg(input logic [18:0] x, input logic [18:0] y);
    return 21'(x & 19'h66739) | {y[5], y[10], 2'b0, y[17], y[18], 2'b0, y[14], y[13], 3'b0, y[9], y[8], 3'b0,
      y[4], y[3], 1'b0};
  endfunction : mrg
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
    tests_run++;
    if (s !== e)
    begin
      fail_count++;
      $display("[FAIL] %0t %s seen %h exp %h", $time, m, s, e);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [3:0] a, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    do @(posedge clk); while (ack !== 1'b1);
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic wait_ex;
    n = 0;
    do @(posedge clk); while (ex !== 1'b1 && ++n < 20);
    chk(ex, 1'b1, "executed");
  endtask : wait_ex
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    fail_count++;
    finish_test;
  end
  initial
  begin
    rst = 1'b1;
    drst_n = 1'b1;
    wide = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, 4'h8, d);
    chk(d[7], 1'b0, "cfg1 bit7");
    wb(1'b1, 4'h4, d);
    wb(1'b0, 4'h4, d);
    chk(d, 32'h0, "write ignored");
    wb(1'b0, 4'h1, d);
    chk(d, 32'h0, "unmapped");
    $display("reset test done");
    host.cmd1(map_pkg::MAP_CMD_RD, 4'h2, 19'h00400);
    wait_ex;
    chk(ex_addr, 21'h00400, "direct addr");
    chk(busy, 1'b1, "row busy");
    host.cmd1(map_pkg::MAP_CMD_MRS, 4'h0, 19'h00200);
    chk(mux, 1'b1, "mode on");
    host.cmd2(map_pkg::MAP_CMD_MRS, 4'h0, 19'h00200, 19'h00000);
    host.cmd2(map_pkg::MAP_CMD_MRS, 4'h1, 19'h00000, 19'h00010);
    host.cmd2(map_pkg::MAP_CMD_MRS, 4'h2, 19'h00000, 19'h00000);
    repeat (8) @(posedge clk);
    wb(1'b0, 4'h4, d);
    chk(d, 32'h200, "cfg0");
    wb(1'b0, 4'h8, d);
    chk(d, 32'h4, "cfg1");
    wb(1'b0, 4'h0, d);
    chk({d[2], d[0]}, 2'b11, "status");
    chk(rsel, 2'b01, "termination");
    chk(ren, 1'b1, "termination on");
    $display("mode test done");
    foreach (rows[i])
    begin
      host.cmd2(rows[i].c, rows[i].b, rows[i].x, rows[i].y);
      wait_ex;
      chk(ex_cmd, rows[i].c, "cmd");
      if (rows[i].c == map_pkg::MAP_CMD_BREF)
        chk(ex_bank, rows[i].b, "bank");
      else
        chk(ex_addr, mrg(rows[i].x, rows[i].y), "addr");
      if (rows[i].l != 4'h0)
      begin
        n = 0;
        do @(posedge clk); while (go !== 1'b1 && ++n < 20);
        chk(n + 1, rows[i].l, "latency");
      end
    end
    $display("row test done");
    host.put(map_pkg::MAP_CMD_BREF, 4'h5, 19'h00000);
    host.cmd2(map_pkg::MAP_CMD_RD, 4'h3, rows[0].x, rows[0].y);
    wait_ex;
    chk(ex_cmd, map_pkg::MAP_CMD_BREF, "refresh first");
    @(posedge clk);
    chk(ex, 1'b1, "next exec");
    chk(ex_cmd, map_pkg::MAP_CMD_RD, "read follows");
    chk(ex_addr, mrg(rows[0].x, rows[0].y), "read addr");
    repeat (8) @(posedge clk);
    $display("refresh follow test done");
    drst_n <= 1'b0;
    wide <= 1'b1;
    repeat (4) @(posedge clk);
    drst_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk(mux, 1'b0, "mode off");
    wb(1'b0, 4'h4, d);
    chk(d, 32'h0, "cfg0 cleared");
    $display("device reset test done");
    host.cmd1(map_pkg::MAP_CMD_MRS, 4'h0, 19'h00200);
    host.cmd2(map_pkg::MAP_CMD_MRS, 4'h0, 19'h00200, 19'h00000);
    host.cmd2(map_pkg::MAP_CMD_MRS, 4'h1, 19'h00000, 19'h00000);
    host.cmd2(map_pkg::MAP_CMD_MRS, 4'h2, 19'h00000, 19'h00000);
    host.cmd2(map_pkg::MAP_CMD_RD, 4'h3, rows[0].x, rows[0].y);
    wait_ex;
    chk(mux, 1'b1, "mode again");
    chk(ex_addr, mrg(rows[0].x, rows[0].y) & 21'h0fffff, "wide addr");
    chk(ren, 1'b0, "termination off");
    $display("wide test done");
    finish_test;
  end
endmodule : map_port_tb
